// ==== logic/mmlr_pkg.sv ====
package mmlr_pkg;
  // Flash code space split.
  localparam logic [12:0] FLASH_USER_LO = 13'h0000;
  localparam logic [12:0] FLASH_USER_HI = 13'h07FF;
  localparam logic [12:0] FLASH_LOCK_LO = 13'h0800;
  localparam logic [12:0] FLASH_LOCK_HI = 13'h1FFF;
  // Flash page size in address bits and erase command codes.
  localparam int PAGE_BITS = 9;
  localparam logic [1:0] CMD_PAGE = 2'h1;
  localparam logic [1:0] CMD_MASS = 2'h2;
  // RAM and register space split.
  localparam logic [11:0] RAM_APP0_LO = 12'h000;
  localparam logic [11:0] RAM_APP0_HI = 12'h06F;
  localparam logic [11:0] RAM_ENG0_LO = 12'h070;
  localparam logic [11:0] RAM_ENG0_HI = 12'h0EF;
  localparam logic [11:0] RAM_SHR_LO = 12'h0F0;
  localparam logic [11:0] RAM_ADV_HI = 12'h0FF;
  localparam logic [11:0] RAM_SHR_HI = 12'h10F;
  localparam logic [11:0] RAM_APP1_LO = 12'h110;
  localparam logic [11:0] RAM_APP1_HI = 12'h18F;
  localparam logic [11:0] RAM_ENG1_LO = 12'h190;
  localparam logic [11:0] RAM_ENG1_HI = 12'h3FF;
  localparam logic [11:0] HOLE_LO = 12'h400;
  localparam logic [11:0] HOLE_HI = 12'hEFF;
  localparam logic [11:0] CREG_LO = 12'hF00;
  // Region codes of a data access.
  typedef enum logic [2:0] {
    MMLR_RG_APP, MMLR_RG_ENGINE, MMLR_RG_SHARED, MMLR_RG_ADVANCED, MMLR_RG_CTRL, MMLR_RG_HOLE
  } mmlr_region_e;
endpackage

// ==== logic/mmlr_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for a pin level.
module mmlr_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  logic meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ==== logic/mmlr_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Refuse every page erase in locked flash region.
// - Low flash area erasable by user.
// - Two engine RAM ranges denied to application.
// - Two application RAM ranges, 240 bytes.
// - Top range decodes as control registers.
// - Middle hole maps no memory.
// - Shared window exchanges engine and application data.
// - Advanced registers in lower shared sixteen bytes.
// - Low reset pin puts device in reset.
// - Device drives reset pin low in reset.
// - One open-drain debug line, both directions.
module mmlr_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic debug_line_in,
  output logic debug_line_out,
  output logic debug_line_oe,
  input wire logic dbg_drive_low,
  output logic dbg_rx,
  input wire logic erase_req,
  input wire logic [1:0] erase_cmd,
  input wire logic [12:0] erase_addr,
  output logic erase_go,
  output logic erase_mass_user,
  output logic [12:0] erase_page_addr,
  output logic erase_refused,
  input wire logic data_req,
  input wire logic data_engine,
  input wire logic [11:0] data_addr,
  output logic data_ok,
  output logic data_fault,
  output logic [2:0] data_region,
  output logic core_reset
);
  logic rst_pin_s;
  logic dbg_s;
  logic in_lock;
  logic in_user;
  mmlr_pkg::mmlr_region_e region;
  logic allowed;

  // Pin levels enter through synchronisers.
  mmlr_sync u_rst_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .din(reset_pin_in),
    .dout(rst_pin_s)
  );
  mmlr_sync u_dbg_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .din(debug_line_in),
    .dout(dbg_s)
  );

  // Device is in reset while srst or the pin is low; it pulls the pin low then.
  // The pin data is a low level held in a flop, so the output leaves a register.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      core_reset <= 1'b1;
      reset_pin_oe <= 1'b1;
      reset_pin_out <= 1'b0;
    end else begin
      core_reset <= ~rst_pin_s;
      reset_pin_oe <= ~rst_pin_s;
      reset_pin_out <= 1'b0;
    end
  end

  // Open-drain debug line: drive low only, receive the settled level.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      debug_line_oe <= 1'b0;
      debug_line_out <= 1'b0;
      dbg_rx <= 1'b1;
    end else begin
      debug_line_oe <= dbg_drive_low;
      debug_line_out <= 1'b0;
      dbg_rx <= dbg_s;
    end
  end

  // Flash region decode.
  assign in_lock = erase_addr >= mmlr_pkg::FLASH_LOCK_LO;
  assign in_user = erase_addr <= mmlr_pkg::FLASH_USER_HI;

  // Erase filter: mass erase is cut down to the user area, page erase into the
  // locked area is refused, so no locked byte is ever touched.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      erase_go <= 1'b0;
      erase_mass_user <= 1'b0;
      erase_page_addr <= mmlr_pkg::FLASH_USER_LO;
      erase_refused <= 1'b0;
    end else begin
      erase_go <= 1'b0;
      erase_mass_user <= 1'b0;
      erase_refused <= 1'b0;
      if (erase_req) begin
        if (erase_cmd == mmlr_pkg::CMD_MASS) begin
          erase_go <= 1'b1;
          erase_mass_user <= 1'b1;
          erase_page_addr <= mmlr_pkg::FLASH_USER_LO;
        end else if (erase_cmd == mmlr_pkg::CMD_PAGE && in_user) begin
          erase_go <= 1'b1;
          erase_page_addr <= {erase_addr[12:mmlr_pkg::PAGE_BITS],
                              {mmlr_pkg::PAGE_BITS{1'b0}}};
        end else if (erase_cmd == mmlr_pkg::CMD_PAGE && in_lock) begin
          erase_refused <= 1'b1;
        end else begin
          erase_refused <= 1'b1;
        end
      end
    end
  end

  // RAM and register space decode.
  always_comb begin
    if (data_addr >= mmlr_pkg::CREG_LO) begin
      region = mmlr_pkg::MMLR_RG_CTRL;
    end else if (data_addr >= mmlr_pkg::HOLE_LO) begin
      region = mmlr_pkg::MMLR_RG_HOLE;
    end else if (data_addr >= mmlr_pkg::RAM_ENG1_LO) begin
      region = mmlr_pkg::MMLR_RG_ENGINE;
    end else if (data_addr >= mmlr_pkg::RAM_APP1_LO) begin
      region = mmlr_pkg::MMLR_RG_APP;
    end else if (data_addr > mmlr_pkg::RAM_ADV_HI) begin
      region = mmlr_pkg::MMLR_RG_SHARED;
    end else if (data_addr >= mmlr_pkg::RAM_SHR_LO) begin
      region = mmlr_pkg::MMLR_RG_ADVANCED;
    end else if (data_addr >= mmlr_pkg::RAM_ENG0_LO) begin
      region = mmlr_pkg::MMLR_RG_ENGINE;
    end else begin
      region = mmlr_pkg::MMLR_RG_APP;
    end
  end

  // Access permission by region and requester.
  always_comb begin
    case (region)
      mmlr_pkg::MMLR_RG_APP: allowed = ~data_engine;
      mmlr_pkg::MMLR_RG_ENGINE: allowed = data_engine;
      mmlr_pkg::MMLR_RG_SHARED: allowed = 1'b1;
      mmlr_pkg::MMLR_RG_ADVANCED: allowed = 1'b1;
      mmlr_pkg::MMLR_RG_CTRL: allowed = 1'b1;
      mmlr_pkg::MMLR_RG_HOLE: allowed = 1'b0;
      default: allowed = 1'b0;
    endcase
  end

  // Registered access answer, one cycle after the request.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_ok <= 1'b0;
      data_fault <= 1'b0;
      data_region <= mmlr_pkg::MMLR_RG_APP;
    end else begin
      data_ok <= data_req & allowed;
      data_fault <= data_req & ~allowed;
      data_region <= region;
    end
  end

  // Reset drives the pin low and holds the core.
  property p_rst_pin;
    @(posedge sys_clk) disable iff (srst) core_reset |-> reset_pin_oe;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin not driven in reset");

  property p_rst_in;
    @(posedge sys_clk) disable iff (srst) !rst_pin_s |=> core_reset;
  endproperty
  a_rst_in: assert property (p_rst_in) else $error("pin low did not reset");

  property p_lock_page;
    @(posedge sys_clk) disable iff (srst)
      erase_req && erase_cmd == mmlr_pkg::CMD_PAGE && erase_addr >= mmlr_pkg::FLASH_LOCK_LO
      |=> erase_refused && !erase_go;
  endproperty
  a_lock_page: assert property (p_lock_page) else $error("locked page erased");

  property p_go_user;
    @(posedge sys_clk) disable iff (srst) erase_go |-> erase_page_addr <= mmlr_pkg::FLASH_USER_HI;
  endproperty
  a_go_user: assert property (p_go_user) else $error("erase outside user area");

  property p_user_page;
    @(posedge sys_clk) disable iff (srst)
      erase_req && erase_cmd == mmlr_pkg::CMD_PAGE && erase_addr <= mmlr_pkg::FLASH_USER_HI
      |=> erase_go;
  endproperty
  a_user_page: assert property (p_user_page) else $error("user page not erased");

  property p_engine_ram;
    @(posedge sys_clk) disable iff (srst)
      data_req && !data_engine && data_addr >= mmlr_pkg::RAM_ENG1_LO
      && data_addr <= mmlr_pkg::RAM_ENG1_HI |=> data_fault;
  endproperty
  a_engine_ram: assert property (p_engine_ram) else $error("engine RAM open to app");

  property p_app_ram;
    @(posedge sys_clk) disable iff (srst)
      data_req && !data_engine && data_addr >= mmlr_pkg::RAM_APP1_LO
      && data_addr <= mmlr_pkg::RAM_APP1_HI |=> data_ok;
  endproperty
  a_app_ram: assert property (p_app_ram) else $error("app RAM refused");

  property p_hole;
    @(posedge sys_clk) disable iff (srst)
      data_req && data_addr >= mmlr_pkg::HOLE_LO && data_addr <= mmlr_pkg::HOLE_HI
      |=> data_fault && !data_ok;
  endproperty
  a_hole: assert property (p_hole) else $error("hole answered");

  property p_ctrl;
    @(posedge sys_clk) disable iff (srst) data_req && data_addr >= mmlr_pkg::CREG_LO |=> data_ok;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control space refused");

  property p_adv;
    @(posedge sys_clk) disable iff (srst)
      data_req && data_addr >= mmlr_pkg::RAM_SHR_LO && data_addr <= mmlr_pkg::RAM_ADV_HI
      |=> data_ok && data_region == mmlr_pkg::MMLR_RG_ADVANCED;
  endproperty
  a_adv: assert property (p_adv) else $error("advanced window wrong");

  property p_dbg;
    @(posedge sys_clk) disable iff (srst) dbg_drive_low |=> debug_line_oe;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug line not driven");

  // A released debugger lets the wire go back to its pull-up.
  property p_dbg_release;
    @(posedge sys_clk) disable iff (srst) !dbg_drive_low |=> !debug_line_oe;
  endproperty
  a_dbg_release: assert property (p_dbg_release) else $error("debug line held low");

  // A settled high pin lets the core run again.
  property p_rst_release;
    @(posedge sys_clk) disable iff (srst) rst_pin_s |=> !core_reset && !reset_pin_oe;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("reset held with pin high");

  // Mass erase is narrowed to the user area instead of reaching locked code.
  property p_mass;
    @(posedge sys_clk) disable iff (srst)
      erase_req && erase_cmd == mmlr_pkg::CMD_MASS
      |=> erase_go && erase_mass_user && erase_page_addr == mmlr_pkg::FLASH_USER_LO;
  endproperty
  a_mass: assert property (p_mass) else $error("mass erase not limited");

  // Unknown command codes never start an erase.
  property p_bad_cmd;
    @(posedge sys_clk) disable iff (srst)
      erase_req && erase_cmd != mmlr_pkg::CMD_PAGE && erase_cmd != mmlr_pkg::CMD_MASS
      |=> erase_refused && !erase_go;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad erase command ran");

  // An erase answer is either a start or a refusal, never both.
  property p_erase_excl;
    @(posedge sys_clk) disable iff (srst) !(erase_go && erase_refused);
  endproperty
  a_erase_excl: assert property (p_erase_excl) else $error("erase both started and refused");

  // A data answer is either granted or faulted, never both.
  property p_data_excl;
    @(posedge sys_clk) disable iff (srst) !(data_ok && data_fault);
  endproperty
  a_data_excl: assert property (p_data_excl) else $error("data both ok and fault");

  // The lower engine range is closed to the application.
  property p_eng0;
    @(posedge sys_clk) disable iff (srst)
      data_req && !data_engine && data_addr >= mmlr_pkg::RAM_ENG0_LO
      && data_addr <= mmlr_pkg::RAM_ENG0_HI |=> data_fault;
  endproperty
  a_eng0: assert property (p_eng0) else $error("lower engine RAM open to app");

  // The lower application range is closed to the engine.
  property p_app0;
    @(posedge sys_clk) disable iff (srst)
      data_req && data_engine && data_addr <= mmlr_pkg::RAM_APP0_HI |=> data_fault;
  endproperty
  a_app0: assert property (p_app0) else $error("app RAM open to engine");

  // The upper shared range answers both requesters.
  property p_shared;
    @(posedge sys_clk) disable iff (srst)
      data_req && data_addr > mmlr_pkg::RAM_ADV_HI && data_addr <= mmlr_pkg::RAM_SHR_HI
      |=> data_ok && data_region == mmlr_pkg::MMLR_RG_SHARED;
  endproperty
  a_shared: assert property (p_shared) else $error("shared window wrong");
endmodule

// ==== sim/mmlr_pin_host.sv ====
`timescale 1ns/1ps
// External host on the reset pin and the debug line, both with pull-ups.
module mmlr_pin_host (
  input wire logic ext_rst_low,
  input wire logic ext_dbg_low,
  input wire logic debug_line_oe,
  output logic reset_pin_in,
  output logic debug_line_in
);
  // The host pulls reset low; the device's own pull is left out so it cannot lock the wire.
  assign reset_pin_in = ~ext_rst_low;
  // Either party pulls the debug wire low, the pull-up lifts it otherwise.
  assign debug_line_in = ~(ext_dbg_low | debug_line_oe);
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the memory map, flash lock and pin logic.
module tb_top;
  logic sys_clk, srst, reset_pin_in, reset_pin_out, reset_pin_oe, debug_line_in;
  logic debug_line_out, debug_line_oe, dbg_drive_low, dbg_rx, erase_req, erase_go;
  logic erase_mass_user, erase_refused, data_req, data_engine, data_ok, data_fault;
  logic core_reset, ext_rst_low, ext_dbg_low;
  logic [1:0] erase_cmd;
  logic [12:0] erase_addr, erase_page_addr, ra;
  logic [11:0] data_addr;
  logic [2:0] data_region;
  logic [15:0] er_q[$], e;
  logic [4:0] da_q[$], d;
  int n_mismatch, tests_run;
  mmlr_top DUT (.sys_clk, .srst, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .debug_line_in,
    .debug_line_out, .debug_line_oe, .dbg_drive_low, .dbg_rx, .erase_req, .erase_cmd,
    .erase_addr, .erase_go, .erase_mass_user, .erase_page_addr, .erase_refused, .data_req,
    .data_engine, .data_addr, .data_ok, .data_fault, .data_region, .core_reset);
  mmlr_pin_host host (.ext_rst_low, .ext_dbg_low, .debug_line_oe, .reset_pin_in,
    .debug_line_in);
  // The clock runs at 200 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Compares one value and counts the comparison.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic finish_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Presents one erase request for one cycle and notes {go, refused, mass, page}.
  task automatic erase(input logic [1:0] c, input logic [12:0] a, input logic [2:0] r);
    erase_req = 1'b1;
    erase_cmd = c;
    erase_addr = a;
    er_q.push_back({r, r[2] && !r[0] ? a & 13'h1E00 : 13'h0000});
    @(negedge sys_clk);
  endtask
  // Presents one data access for one cycle and notes {ok, fault, region}.
  task automatic access(input logic eng, input logic [11:0] a, input logic ok,
    input mmlr_pkg::mmlr_region_e rg);
    data_req = 1'b1;
    data_engine = eng;
    data_addr = a;
    da_q.push_back({ok, ~ok, rg});
    @(negedge sys_clk);
  endtask
  // Takes the oldest note off each queue when the matching answer shows.
  always @(negedge sys_clk) begin
    if (erase_go === 1'b1 || erase_refused === 1'b1) begin
      e = er_q.size() > 0 ? er_q.pop_front() : 16'hFFFF;
      chk("erase", {erase_go, erase_refused, erase_mass_user,
        e[14] ? e[12:0] : erase_page_addr}, e);
    end
    if (data_ok === 1'b1 || data_fault === 1'b1) begin
      d = da_q.size() > 0 ? da_q.pop_front() : 5'h1F;
      chk("data", {11'h000, data_ok, data_fault, data_region}, {11'h000, d});
    end
  end
  // Cuts a hang short.
  initial begin
    #10000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence: reset, erase table, data map, reset pin, debug line.
  initial begin
    {srst, dbg_drive_low, erase_req, erase_cmd, erase_addr} = 18'h20000;
    {data_req, data_engine, data_addr, ext_rst_low, ext_dbg_low} = 16'h0000;
    void'($urandom(30));
    repeat (6) @(negedge sys_clk);
    chk("in_reset", 16'({core_reset, reset_pin_oe}), 16'h3);
    srst = 1'b0;
    @(negedge sys_clk);
    chk("after_reset", 16'({core_reset, reset_pin_oe}), 16'h0);
    erase(mmlr_pkg::CMD_PAGE, 13'h0000, 3'b100);
    erase(mmlr_pkg::CMD_PAGE, 13'h0800, 3'b010);
    erase(mmlr_pkg::CMD_PAGE, 13'h07FF, 3'b100);
    erase(mmlr_pkg::CMD_PAGE, 13'h1FFF, 3'b010);
    erase(mmlr_pkg::CMD_MASS, 13'h1234, 3'b101);
    erase(2'h0, 13'h0200, 3'b010);
    erase(2'h3, 13'h0200, 3'b010);
    for (int i = 0; i < 8; i++) begin
      ra = 13'($urandom % 13'h1800);
      erase(mmlr_pkg::CMD_PAGE, 13'($urandom) & 13'h07FF, 3'b100);
      erase(mmlr_pkg::CMD_PAGE, 13'h0800 + ra, 3'b010);
    end
    erase_req = 1'b0;
    access(1'b0, 12'h06F, 1'b1, mmlr_pkg::MMLR_RG_APP);
    access(1'b0, 12'h070, 1'b0, mmlr_pkg::MMLR_RG_ENGINE);
    access(1'b1, 12'h0EF, 1'b1, mmlr_pkg::MMLR_RG_ENGINE);
    access(1'b0, 12'h0F0, 1'b1, mmlr_pkg::MMLR_RG_ADVANCED);
    access(1'b1, 12'h0FF, 1'b1, mmlr_pkg::MMLR_RG_ADVANCED);
    access(1'b0, 12'h100, 1'b1, mmlr_pkg::MMLR_RG_SHARED);
    access(1'b1, 12'h10F, 1'b1, mmlr_pkg::MMLR_RG_SHARED);
    access(1'b0, 12'h110, 1'b1, mmlr_pkg::MMLR_RG_APP);
    access(1'b1, 12'h18F, 1'b0, mmlr_pkg::MMLR_RG_APP);
    access(1'b0, 12'h190, 1'b0, mmlr_pkg::MMLR_RG_ENGINE);
    access(1'b0, 12'h3FF, 1'b0, mmlr_pkg::MMLR_RG_ENGINE);
    access(1'b0, 12'h400, 1'b0, mmlr_pkg::MMLR_RG_HOLE);
    access(1'b1, 12'hEFF, 1'b0, mmlr_pkg::MMLR_RG_HOLE);
    access(1'b0, 12'hF00, 1'b1, mmlr_pkg::MMLR_RG_CTRL);
    access(1'b1, 12'hFFF, 1'b1, mmlr_pkg::MMLR_RG_CTRL);
    data_req = 1'b0;
    ext_rst_low = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("pin_reset", 16'({core_reset, reset_pin_oe, reset_pin_out}), 16'h6);
    ext_rst_low = 1'b0;
    srst = 1'b1;
    @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("pin_release", 16'({core_reset, reset_pin_oe}), 16'h0);
    dbg_drive_low = 1'b1;
    @(negedge sys_clk);
    chk("dbg_oe", 16'({debug_line_oe, debug_line_out}), 16'h2);
    repeat (3) @(negedge sys_clk);
    chk("dbg_rx_low", 16'(dbg_rx), 16'h0);
    dbg_drive_low = 1'b0;
    ext_dbg_low = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("dbg_host", 16'({debug_line_oe, dbg_rx}), 16'h0);
    ext_dbg_low = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("dbg_rx_high", 16'(dbg_rx), 16'h1);
    chk("queues", 16'(er_q.size() + da_q.size()), 16'h0);
    finish_test();
  end
endmodule
